// *** common/ppp_pkg.sv ***
// Purpose: Constants and types for the PROM programming-port host.
// Assumes: One 125 MHz system clock; pins timed in whole cycles.
// Notes: Supply levels are reported as a two-bit level request.
// Operation
// - Host writes only addresses 0000H to EFFFH and always includes EFFFH.
// - Full page latched, 0.1 ms strobe pulse with enables high writes page.
// - After page write, both enables low verifies the stored data.
// - Repeat write and verify on mismatch, at most ten attempts.
// - Chip enable low, output enable high, 0.1 ms strobe writes one byte.
// - After byte write, output enable low drives the programmed byte.
// - Host reads with reset low, read level, address on seventeen pins; a read after a write gets program level in its first cycle.
package ppp_pkg;
  // ==========================================================
  // Address space and data
  localparam int ADDR_W = 17;
  localparam logic [16:0] ADDR_LAST = 17'h0_EFFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int PAGE_BYTES = 4;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int PULSE_NS = 100000;
  localparam int PULSE_CYC = PULSE_NS / CLK_PERIOD_NS;
  localparam int SETUP_CYC = 4;
  localparam int MAX_TRIES = 10;
  // ==========================================================
  // Supply level request
  localparam logic [1:0] SUP_OFF = 2'h0;
  localparam logic [1:0] SUP_READ = 2'h1;
  localparam logic [1:0] SUP_PROG = 2'h2;
  // Commands
  typedef enum logic [1:0] {
    PPP_CMD_READ = 2'b00,
    PPP_CMD_BYTE = 2'b01,
    PPP_CMD_PAGE = 2'b10
  } ppp_cmd_t;
  // Strobe group driven to the device
  typedef struct packed {
    logic chip_enable_n;
    logic output_enable_n;
    logic program_strobe_n;
  } ppp_strobe_t;
endpackage : ppp_pkg

// *** hw/ppp_host.sv ***
// Purpose: Programmer that drives the PROM pins: read, byte and page write.
// Assumes: Device is held in programming mode by reset_n_pin low.
// Notes: Page writes take four bytes on req; one request per byte.
`timescale 1ns/10ps
module ppp_host #(
  parameter int PULSE_CYC = ppp_pkg::PULSE_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire ppp_pkg::ppp_cmd_t req_cmd,
  input wire logic [16:0] req_addr,
  input wire logic [7:0] req_data,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_error,
  output logic dev_reset_n,
  output logic [1:0] supply_level,
  output logic [16:0] address_pins,
  output logic [7:0] data_pins_o,
  output logic data_pins_oe,
  input wire logic [7:0] data_pins_i,
  output ppp_pkg::ppp_strobe_t strobes
);
  // ==========================================================
  // State machine
  typedef enum logic [2:0] {
    PPP_IDLE = 3'b000,
    PPP_SETUP = 3'b001,
    PPP_LATCH = 3'b010,
    PPP_PULSE = 3'b011,
    PPP_VSET = 3'b100,
    PPP_VCHK = 3'b101,
    PPP_DONE = 3'b110
  } ppp_state_t;

  ppp_state_t state_r, state_nxt;
  ppp_pkg::ppp_cmd_t cmd_r;
  logic [31:0] cnt_r;
  logic [3:0] tries_r;
  logic [1:0] slot_r;
  logic [16:0] page_base_r;
  logic [31:0] page_data_r;
  logic [7:0] din_s1_r, din_s2_r;
  logic [1:0] vslot_r;

  // Pin data is asynchronous to sys_clk: two stages before use
  always_ff @(posedge sys_clk) begin
    din_s1_r <= data_pins_i;
    din_s2_r <= din_s1_r;
  end

  // ==========================================================
  // Decode
  wire cnt_done = (cnt_r == 32'h0000_0000);
  wire take = req_valid && req_ready;
  // Out of range writes are refused, reads allowed over the full pins
  wire bad_addr = (req_cmd != ppp_pkg::PPP_CMD_READ) &&
                  (req_addr > ppp_pkg::ADDR_LAST);
  wire [7:0] expect_byte = (cmd_r == ppp_pkg::PPP_CMD_PAGE) ?
    page_data_r[{vslot_r, 3'b000} +: 8] : page_data_r[7:0];
  wire match = (din_s2_r == expect_byte);
  wire last_v = (cmd_r != ppp_pkg::PPP_CMD_PAGE) ||
                (vslot_r == 2'h3);

  // Next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PPP_IDLE: begin
        if (take && !bad_addr) begin
          state_nxt = (req_cmd == ppp_pkg::PPP_CMD_PAGE) ?
            PPP_LATCH : PPP_SETUP;
        end
      end
      PPP_LATCH: begin
        if (cnt_done) begin
          state_nxt = (slot_r == 2'h3) ? PPP_SETUP : PPP_IDLE;
        end
      end
      PPP_SETUP: begin
        if (cnt_done) begin
          // Reads also settle through the pin synchroniser first
          state_nxt = (cmd_r == ppp_pkg::PPP_CMD_READ) ?
            PPP_VSET : PPP_PULSE;
        end
      end
      PPP_PULSE: if (cnt_done) state_nxt = PPP_VSET;
      PPP_VSET: if (cnt_done) state_nxt = PPP_VCHK;
      PPP_VCHK: begin
        if (cmd_r == ppp_pkg::PPP_CMD_READ) begin
          state_nxt = PPP_DONE;
        end else if (!match && tries_r < 4'(ppp_pkg::MAX_TRIES)) begin
          state_nxt = PPP_SETUP;
        end else if (!match || last_v) begin
          state_nxt = PPP_DONE;
        end else begin
          state_nxt = PPP_VSET;
        end
      end
      PPP_DONE: state_nxt = PPP_IDLE;
      default: state_nxt = PPP_IDLE;
    endcase
  end

  // ==========================================================
  // Sequencer registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_r <= PPP_IDLE;
      cmd_r <= ppp_pkg::PPP_CMD_READ;
      cnt_r <= 32'h0000_0000;
      tries_r <= 4'h0;
      slot_r <= 2'h0;
      vslot_r <= 2'h0;
      page_base_r <= 17'h0_0000;
      page_data_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      if (cnt_r != 32'h0000_0000) cnt_r <= cnt_r - 32'h0000_0001;
      if (state_r == PPP_IDLE && take && !bad_addr) begin
        cmd_r <= req_cmd;
        cnt_r <= 32'(ppp_pkg::SETUP_CYC);
        tries_r <= 4'h0;
        vslot_r <= 2'h0;
        slot_r <= req_addr[1:0];
        page_base_r <= {req_addr[16:2], 2'b00};
        if (req_cmd == ppp_pkg::PPP_CMD_PAGE) begin
          page_data_r[{req_addr[1:0], 3'b000} +: 8] <= req_data;
        end else begin
          page_data_r <= {24'h00_0000, req_data};
          page_base_r <= req_addr;
        end
      end
      if (state_nxt == PPP_PULSE && state_r != PPP_PULSE) begin
        cnt_r <= 32'(PULSE_CYC - 1);
        tries_r <= tries_r + 4'h1;
      end
      if (state_nxt == PPP_VSET && state_r != PPP_VSET) begin
        cnt_r <= 32'(ppp_pkg::SETUP_CYC);
      end
      if (state_r == PPP_VCHK && state_nxt == PPP_VSET) begin
        vslot_r <= vslot_r + 2'h1;
      end
      if (state_r == PPP_VCHK && state_nxt == PPP_SETUP) begin
        vslot_r <= 2'h0;
        cnt_r <= 32'(ppp_pkg::SETUP_CYC);
      end
    end
  end

  // ==========================================================
  // Pin drive: all outputs registered
  wire prog_lvl = (cmd_r != ppp_pkg::PPP_CMD_READ);
  wire in_pulse = (state_nxt == PPP_PULSE);
  wire in_latch = (state_nxt == PPP_LATCH);
  wire in_verify = (state_nxt == PPP_VSET) || (state_nxt == PPP_VCHK);
  wire is_page = (cmd_r == ppp_pkg::PPP_CMD_PAGE) ||
                 (state_r == PPP_IDLE && req_cmd == ppp_pkg::PPP_CMD_PAGE);
  wire [16:0] pin_addr =
    (state_r == PPP_IDLE) ? req_addr :
    (is_page && in_verify) ? (page_base_r | {15'h0000, vslot_r}) :
    (is_page && !in_latch) ? page_base_r : address_pins;
  // Page strobes use chip enable high; byte and read use chip enable low
  wire ce_n_nxt = is_page ? !in_verify
                          : !(in_verify || in_pulse ||
                              state_nxt == PPP_SETUP);
  wire oe_n_nxt = !(in_latch || in_verify);
  wire pgm_n_nxt = !in_pulse;
  // Page pulse leaves the data pins floating; page latch drives them
  wire drive_nxt = in_latch || (in_pulse && !is_page);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      dev_reset_n <= 1'b0;
      supply_level <= ppp_pkg::SUP_OFF;
      address_pins <= 17'h0_0000;
      data_pins_o <= 8'h00;
      data_pins_oe <= 1'b0;
      strobes <= '{1'b1, 1'b1, 1'b1};
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= ppp_pkg::ERASED_BYTE;
      rsp_error <= 1'b0;
    end else begin
      dev_reset_n <= 1'b0;
      supply_level <= (state_nxt == PPP_IDLE) ? ppp_pkg::SUP_OFF :
        prog_lvl || (state_r == PPP_IDLE && req_cmd !=
          ppp_pkg::PPP_CMD_READ) ? ppp_pkg::SUP_PROG :
        ppp_pkg::SUP_READ;
      address_pins <= pin_addr;
      data_pins_o <= in_latch && state_r == PPP_IDLE ? req_data :
        in_pulse && !is_page ? page_data_r[7:0] : data_pins_o;
      data_pins_oe <= drive_nxt;
      strobes <= '{ce_n_nxt, oe_n_nxt, pgm_n_nxt};
      req_ready <= (state_nxt == PPP_IDLE);
      rsp_valid <= (state_r == PPP_DONE) ||
        (state_r == PPP_IDLE && take && bad_addr) ||
        (state_r == PPP_LATCH && state_nxt == PPP_IDLE);
      if (state_r == PPP_VCHK) begin
        rsp_data <= din_s2_r;
        rsp_error <= (cmd_r != ppp_pkg::PPP_CMD_READ) && !match;
      end else if (state_r == PPP_IDLE && take) begin
        rsp_error <= bad_addr;
      end
    end
  end

  // ==========================================================
  // Checks
  a_pulse_enables: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    !strobes.program_strobe_n |-> strobes.output_enable_n)
    else $error("Program strobe low while output enabled");
  // Host drives only while the device cannot be reading out
  a_no_contention: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    data_pins_oe |-> strobes.output_enable_n || strobes.chip_enable_n)
    else $error("Host drives data during device output");
  a_tries_bound: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    tries_r <= 4'(ppp_pkg::MAX_TRIES))
    else $error("Too many program attempts");
  a_write_range: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    !strobes.program_strobe_n |-> address_pins <= ppp_pkg::ADDR_LAST)
    else $error("Write outside program space");
  a_reset_low: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    supply_level != ppp_pkg::SUP_OFF |-> !dev_reset_n)
    else $error("Supply applied with device reset released");
  a_pulse_level: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    !strobes.program_strobe_n |-> supply_level == ppp_pkg::SUP_PROG)
    else $error("Program strobe low without program supply");
endmodule : ppp_host

// *** sim/ppp_prom_model.sv ***
// Purpose: Behavioural PROM device on the far side of the programming host.
// Assumes: Pins are sampled on sys_clk; pulse width is counted in cycles.
// Notes: A byte write to stuck_addr never takes, so the host has to retry.
`timescale 1ns/10ps
module ppp_prom_model #(
  parameter int PULSE_CYC = 20
) (
  input wire logic sys_clk,
  input wire logic dev_reset_n,
  input wire logic [1:0] supply_level,
  input wire logic [16:0] address_pins,
  input wire logic [7:0] bus_level,
  input wire ppp_pkg::ppp_strobe_t strobes,
  input wire logic [16:0] stuck_addr,
  output logic [7:0] dev_data,
  output logic dev_oe,
  output int pulse_count
);
  // ==========================================================
  // Mode decode
  logic [7:0] mem [131072];
  logic wce_n_r;
  logic [7:0] page [4];
  logic [16:2] base_r;
  logic [16:0] wa_r;
  logic [7:0] wd_r;
  logic [7:0] rd_r;
  int low_cyc = 0;
  wire in_mode = !dev_reset_n && supply_level != ppp_pkg::SUP_OFF;
  wire prog = in_mode && supply_level == ppp_pkg::SUP_PROG;
  wire ce_n = strobes.chip_enable_n;
  wire oe_n = strobes.output_enable_n;
  wire pg_n = strobes.program_strobe_n;
  // Drives only in read or verify, floats in every other mode
  assign dev_oe = in_mode && !ce_n && !oe_n && pg_n;
  assign dev_data = rd_r;
  // Whole array starts erased
  initial begin
    pulse_count = 0;
    for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
  end
  // Latch, pulse timing and array update; short pulses write nothing
  always @(posedge sys_clk) begin
    rd_r <= mem[address_pins];
    if (prog && ce_n && pg_n && !oe_n) begin
      page[address_pins[1:0]] <= bus_level;
      base_r <= address_pins[16:2];
    end
    low_cyc <= (prog && !pg_n && oe_n) ? low_cyc + 1 : 0;
    if (!pg_n) begin
      wa_r <= address_pins;
      wd_r <= bus_level;
      wce_n_r <= ce_n;
    end
    // Page or byte is judged by chip enable during the pulse itself
    if (prog && pg_n && low_cyc >= PULSE_CYC) begin
      pulse_count <= pulse_count + 1;
      if (!wce_n_r && wa_r != stuck_addr) mem[wa_r] = wd_r;
      if (wce_n_r) begin
        for (int i = 0; i < 4; i++) begin
          mem[{base_r, 2'(i)}] = page[i];
        end
      end
    end
  end
endmodule : ppp_prom_model

// *** sim/testbench.sv ***
// Purpose: Self-checking bench for the PROM programming host.
// Assumes: Pulse shortened to 20 cycles; device is the behavioural model.
// Notes: A released data bus shows the inverse of its last level.
`timescale 1ns/10ps
module testbench;
  // ==========================================================
  // Stimulus, wiring and checks
  localparam int PW = 20;
  logic sys_clk = 0;
  logic resetn = 0;
  logic req_valid = 0;
  ppp_pkg::ppp_cmd_t req_cmd = ppp_pkg::PPP_CMD_READ;
  logic [16:0] req_addr = 17'h0_0000;
  logic [7:0] req_data = 8'h00;
  logic req_ready, rsp_valid, rsp_error, dev_reset_n, data_pins_oe, dev_oe;
  logic [7:0] rsp_data, data_pins_o, dev_data;
  logic [7:0] last_r = 8'h00;
  logic [1:0] supply_level;
  logic [16:0] address_pins;
  ppp_pkg::ppp_strobe_t strobes;
  int pulse_count;
  int fail_count = 0;
  int tests_run = 0;
  wire [7:0] bus_level = data_pins_oe ? data_pins_o :
    dev_oe ? dev_data : ~last_r;
  always @(posedge sys_clk) last_r <= bus_level;
  ppp_host #(.PULSE_CYC(PW)) u_dut (.sys_clk(sys_clk), .resetn(resetn),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr),
    .req_data(req_data), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_error(rsp_error), .dev_reset_n(dev_reset_n),
    .supply_level(supply_level), .address_pins(address_pins),
    .data_pins_o(data_pins_o), .data_pins_oe(data_pins_oe),
    .data_pins_i(bus_level), .strobes(strobes));
  ppp_prom_model #(.PULSE_CYC(PW)) u_prom (.sys_clk(sys_clk),
    .dev_reset_n(dev_reset_n), .supply_level(supply_level),
    .address_pins(address_pins), .bus_level(bus_level), .strobes(strobes),
    .stuck_addr(17'h0_0200), .dev_data(dev_data), .dev_oe(dev_oe),
    .pulse_count(pulse_count));
  initial forever #4 sys_clk = ~sys_clk;
  task summarize;
    if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task check(string what, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // One request, held until taken, then a bounded wait for the answer
  task send(ppp_pkg::ppp_cmd_t c, logic [16:0] a, logic [7:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 5000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    {req_cmd, req_addr, req_data, req_valid} = {c, a, d, 1'b1};
    @(posedge sys_clk);
    #1 req_valid = 0;
    while (rsp_valid !== 1'b1 && n < 5000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (n >= 5000) begin fail_count++; summarize(); end
  endtask : send
  task t_erased;
    send(ppp_pkg::PPP_CMD_READ, 17'h0_0040, 8'h00);
    check("erased byte", 8'hFF, rsp_data);
    check("device reset", 8'h00, {7'h00, dev_reset_n});
  endtask : t_erased
  task t_byte;
    int p;
    p = pulse_count;
    send(ppp_pkg::PPP_CMD_BYTE, 17'h0_0123, 8'h3C);
    check("byte error", 8'h00, {7'h00, rsp_error});
    check("byte pulses", 8'h01, 8'(pulse_count - p));
    send(ppp_pkg::PPP_CMD_READ, 17'h0_0123, 8'h00);
    check("byte readback", 8'h3C, rsp_data);
  endtask : t_byte
  task t_page;
    for (int i = 0; i < 4; i++) begin
      send(ppp_pkg::PPP_CMD_PAGE, 17'h0_EFFC + 17'(i), 8'hA0 + 8'(i));
      check("page error", 8'h00, {7'h00, rsp_error});
    end
    for (int i = 0; i < 4; i++) begin
      send(ppp_pkg::PPP_CMD_READ, 17'h0_EFFC + 17'(i), 8'h00);
      check("page readback", 8'hA0 + 8'(i), rsp_data);
    end
  endtask : t_page
  task t_refuse;
    int p;
    p = pulse_count;
    send(ppp_pkg::PPP_CMD_BYTE, 17'h0_F000, 8'h55);
    check("range error", 8'h01, {7'h00, rsp_error});
    check("range pulses", 8'h00, 8'(pulse_count - p));
  endtask : t_refuse
  task t_retry;
    int p;
    p = pulse_count;
    send(ppp_pkg::PPP_CMD_BYTE, 17'h0_0200, 8'h12);
    check("retry error", 8'h01, {7'h00, rsp_error});
    check("retry pulses", 8'h0A, 8'(pulse_count - p));
  endtask : t_retry
  // Reset, then each scenario in turn
  initial begin
    repeat (10) @(posedge sys_clk);
    #1 resetn = 1;
    @(posedge sys_clk);
    #1;
    t_erased;
    t_byte;
    t_page;
    t_refuse;
    t_retry;
    summarize();
  end
endmodule : testbench
